/* inc/hpcr_pkg.sv */
// Constants and types shared by the hub power and port configuration registers
package hpcr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets, byte-wide configuration space
    localparam logic [7:0] HPCR_OFS_BP_PORT_DIS   = 8'h0b;
    localparam logic [7:0] HPCR_OFS_SP_MAX_PWR    = 8'h0c;
    localparam logic [7:0] HPCR_OFS_BP_MAX_PWR    = 8'h0d;
    localparam logic [7:0] HPCR_OFS_SP_CTRL_CUR   = 8'h0e;
    localparam logic [7:0] HPCR_OFS_BP_CTRL_CUR   = 8'h0f;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] HPCR_RST_BP_PORT_DIS   = 8'h00;
    localparam logic [7:0] HPCR_RST_SP_MAX_PWR    = 8'h00;
    localparam logic [7:0] HPCR_RST_BP_MAX_PWR    = 8'h00;
    localparam logic [7:0] HPCR_RST_SP_CTRL_CUR   = 8'h00;
    localparam logic [7:0] HPCR_RST_BP_CTRL_CUR   = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Port disable field: one flag per downstream port, bits 4..1
    localparam int         HPCR_NUM_PORTS         = 4;
    localparam int         HPCR_PORT_LSB          = 1;
    localparam int         HPCR_PORT_MSB          = 4;
    localparam logic [7:0] HPCR_PORT_DIS_MASK     = 8'h1e;
    localparam logic [7:0] HPCR_RDATA_IDLE        = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Strap decode under the internal default configuration
    localparam logic [1:0] HPCR_STRAP_NONE        = 2'h0;
    localparam logic [1:0] HPCR_STRAP_P4          = 2'h1;
    localparam logic [1:0] HPCR_STRAP_P43         = 2'h2;
    localparam logic [1:0] HPCR_STRAP_P432        = 2'h3;
    localparam logic [3:0] HPCR_DIS_NONE          = 4'h0;
    localparam logic [3:0] HPCR_DIS_P4            = 4'h8;
    localparam logic [3:0] HPCR_DIS_P43           = 4'hc;
    localparam logic [3:0] HPCR_DIS_P432          = 4'he;

    typedef logic [HPCR_NUM_PORTS-1:0] hpcr_port_mask_t;

endpackage : hpcr_pkg

/* inc/hpcr_port_if.sv */
// Carrier between the register bank and the downstream port gate
`timescale 1ns/100ps
interface hpcr_port_if;
    import hpcr_pkg::*;
    hpcr_port_mask_t disable_mask;
    hpcr_port_mask_t enable_req;
    hpcr_port_mask_t disable_req;
    hpcr_port_mask_t port_enabled;

    modport ctrl (
        output disable_mask,
        output enable_req,
        output disable_req,
        input  port_enabled
    );
    modport gate (
        input  disable_mask,
        input  enable_req,
        input  disable_req,
        output port_enabled
    );
endinterface : hpcr_port_if

/* src/hpcr_port_gate.sv */
// Per-port enable state that the upstream host drives, gated by the disable mask
`timescale 1ns/100ps
module hpcr_port_gate
    import hpcr_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  srst,
    hpcr_port_if.gate  pif
);

    hpcr_port_mask_t en_q;
    hpcr_port_mask_t en_d;

    ////////////////////////////////////////////////////////////////////////////
    // Next enable per port; a disabled port can never come up
    for (genvar p = 0; p < HPCR_NUM_PORTS; p++) begin : g_port
        always_comb begin
            if (pif.disable_mask[p]) begin
                en_d[p] = 1'b0;                           // [RQ3]
            end else if (pif.enable_req[p]) begin
                en_d[p] = 1'b1;
            end else if (pif.disable_req[p]) begin
                en_d[p] = 1'b0;
            end else begin
                en_d[p] = en_q[p];
            end
        end
    end

    // Register stage
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            en_q <= '0;
        end else begin
            en_q <= en_d;
        end
    end

    assign pif.port_enabled = en_q;

endmodule : hpcr_port_gate

/* src/hpcr_regs.sv */
// Hub power and bus-powered port disable configuration register bank
//
// Operation
// RQ1: One disable flag per port, bits 4..1
// RQ2: Bits 7, 6, 5, 0 always read zero
// RQ3: Bus-powered flagged ports stay disabled, never enumerated
// RQ4: Loader disables contiguous ports descending from 4
// RQ5: Internal default config takes disables from straps
// RQ6: Self-powered hub max power, 2 mA units
// RQ7: Bus-powered hub max power, 2 mA units
// RQ8: Self-powered controller current, excludes embedded peripheral
// RQ9: Bus-powered controller current, excludes embedded peripheral
// RQ10: Loader keeps self-powered values at 100 mA max
// RQ11: All five registers reset to zero
// RQ12: Report values matching present powering mode
`timescale 1ns/100ps
module hpcr_regs
    import hpcr_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic                      srst,
    // Configuration load port (EEPROM loader or SMBus slave)
    input  wire logic                      cfg_wr,
    input  wire logic                      cfg_rd,
    input  wire logic [7:0]                cfg_addr,
    input  wire logic [7:0]                cfg_wdata,
    output logic      [7:0]                cfg_rdata_q,
    output logic                           cfg_rvalid_q,
    // Hub operating context
    input  wire logic                      self_powered,
    input  wire logic                      default_config_sel,
    input  wire logic [1:0]                port_disable_straps,
    // Upstream host port control
    input  wire logic [HPCR_NUM_PORTS-1:0] host_port_enable_req,
    input  wire logic [HPCR_NUM_PORTS-1:0] host_port_disable_req,
    output logic      [HPCR_NUM_PORTS-1:0] port_enabled,
    output logic      [HPCR_NUM_PORTS-1:0] port_disabled_q,
    // Values reported in the upstream descriptors
    output logic      [7:0]                rpt_max_power_q,
    output logic      [7:0]                rpt_ctrl_current_q,
    // Status
    output logic                           disable_pattern_err_q
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0]      bus_powered_port_disable_q;
    logic [7:0]      bus_powered_port_disable_d;
    logic [7:0]      self_powered_max_power_q;
    logic [7:0]      self_powered_max_power_d;
    logic [7:0]      bus_powered_max_power_q;
    logic [7:0]      bus_powered_max_power_d;
    logic [7:0]      self_powered_controller_current_q;
    logic [7:0]      self_powered_controller_current_d;
    logic [7:0]      bus_powered_controller_current_q;
    logic [7:0]      bus_powered_controller_current_d;

    // Read path
    logic [7:0]      cfg_rdata_d;
    logic            cfg_rvalid_d;

    // Derived control and reporting
    hpcr_port_mask_t strap_mask;
    hpcr_port_mask_t reg_mask;
    hpcr_port_mask_t port_disabled_d;
    logic [7:0]      rpt_max_power_d;
    logic [7:0]      rpt_ctrl_current_d;
    logic            disable_pattern_err_d;

    hpcr_port_if     pif ();

    ////////////////////////////////////////////////////////////////////////////
    // Legal disable sets are empty or a run of ones ending at port 4
    function automatic logic hpcr_is_legal_mask(input hpcr_port_mask_t m);
        logic            ok;
        hpcr_port_mask_t therm;
        ok    = 1'b0;
        therm = '0;
        for (int k = HPCR_NUM_PORTS - 1; k >= -1; k--) begin
            if (m == therm) begin
                ok = 1'b1;
            end
            if (k >= 0) begin
                therm[k] = 1'b1;
            end
        end
        return ok;
    endfunction : hpcr_is_legal_mask

    ////////////////////////////////////////////////////////////////////////////
    // Register write decode; reserved bits are dropped on the way in
    always_comb begin
        bus_powered_port_disable_d        = bus_powered_port_disable_q;
        self_powered_max_power_d          = self_powered_max_power_q;
        bus_powered_max_power_d           = bus_powered_max_power_q;
        self_powered_controller_current_d = self_powered_controller_current_q;
        bus_powered_controller_current_d  = bus_powered_controller_current_q;
        if (cfg_wr) begin
            unique case (cfg_addr)
                HPCR_OFS_BP_PORT_DIS: begin
                    bus_powered_port_disable_d = cfg_wdata & HPCR_PORT_DIS_MASK; // [RQ1] [RQ2]
                end
                HPCR_OFS_SP_MAX_PWR: begin
                    self_powered_max_power_d = cfg_wdata;                      // [RQ6]
                end
                HPCR_OFS_BP_MAX_PWR: begin
                    bus_powered_max_power_d = cfg_wdata;                       // [RQ7]
                end
                HPCR_OFS_SP_CTRL_CUR: begin
                    self_powered_controller_current_d = cfg_wdata;             // [RQ8]
                end
                HPCR_OFS_BP_CTRL_CUR: begin
                    bus_powered_controller_current_d = cfg_wdata;              // [RQ9]
                end
                // Unmapped offsets belong to other banks; ignored here
                default: begin
                end
            endcase
        end
    end

    // Register stage, all cleared by reset
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bus_powered_port_disable_q        <= HPCR_RST_BP_PORT_DIS;    // [RQ11]
            self_powered_max_power_q          <= HPCR_RST_SP_MAX_PWR;     // [RQ11]
            bus_powered_max_power_q           <= HPCR_RST_BP_MAX_PWR;     // [RQ11]
            self_powered_controller_current_q <= HPCR_RST_SP_CTRL_CUR;    // [RQ11]
            bus_powered_controller_current_q  <= HPCR_RST_BP_CTRL_CUR;    // [RQ11]
        end else begin
            bus_powered_port_disable_q        <= bus_powered_port_disable_d;
            self_powered_max_power_q          <= self_powered_max_power_d;
            bus_powered_max_power_q           <= bus_powered_max_power_d;
            self_powered_controller_current_q <= self_powered_controller_current_d;
            bus_powered_controller_current_q  <= bus_powered_controller_current_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; answers one cycle after the strobe, unmapped reads as zero
    always_comb begin
        cfg_rvalid_d = cfg_rd;
        cfg_rdata_d  = HPCR_RDATA_IDLE;
        if (cfg_rd) begin
            unique case (cfg_addr)
                HPCR_OFS_BP_PORT_DIS: begin
                    cfg_rdata_d = bus_powered_port_disable_q & HPCR_PORT_DIS_MASK; // [RQ2]
                end
                HPCR_OFS_SP_MAX_PWR: begin
                    cfg_rdata_d = self_powered_max_power_q;
                end
                HPCR_OFS_BP_MAX_PWR: begin
                    cfg_rdata_d = bus_powered_max_power_q;
                end
                HPCR_OFS_SP_CTRL_CUR: begin
                    cfg_rdata_d = self_powered_controller_current_q;
                end
                HPCR_OFS_BP_CTRL_CUR: begin
                    cfg_rdata_d = bus_powered_controller_current_q;
                end
                default: begin
                    cfg_rdata_d = HPCR_RDATA_IDLE;
                end
            endcase
        end
    end

    // Read data register; data returns to idle when no read is pending
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cfg_rdata_q  <= HPCR_RDATA_IDLE;
            cfg_rvalid_q <= 1'b0;
        end else begin
            cfg_rdata_q  <= cfg_rdata_d;
            cfg_rvalid_q <= cfg_rvalid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strap decode; each code extends the disabled run down from port 4
    always_comb begin
        unique case (port_disable_straps)
            HPCR_STRAP_NONE: strap_mask = HPCR_DIS_NONE;                  // [RQ5]
            HPCR_STRAP_P4:   strap_mask = HPCR_DIS_P4;                    // [RQ5]
            HPCR_STRAP_P43:  strap_mask = HPCR_DIS_P43;                   // [RQ5]
            HPCR_STRAP_P432: strap_mask = HPCR_DIS_P432;                  // [RQ5]
        endcase
    end

    assign reg_mask = bus_powered_port_disable_q[HPCR_PORT_MSB:HPCR_PORT_LSB]; // [RQ1]

    ////////////////////////////////////////////////////////////////////////////
    // Effective disable mask; the bus-powered set only acts when bus-powered.
    // Self-powered disables live in a neighbouring bank, so they are not
    // applied here unless the straps are in charge.
    always_comb begin
        if (default_config_sel) begin
            port_disabled_d = strap_mask;                                 // [RQ5]
        end else if (!self_powered) begin
            port_disabled_d = reg_mask;                                   // [RQ3]
        end else begin
            port_disabled_d = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reported figures follow the present powering mode
    always_comb begin
        if (self_powered) begin
            rpt_max_power_d    = self_powered_max_power_q;                // [RQ12] [RQ6]
            rpt_ctrl_current_d = self_powered_controller_current_q;       // [RQ12] [RQ8]
        end else begin
            rpt_max_power_d    = bus_powered_max_power_q;                 // [RQ12] [RQ7]
            rpt_ctrl_current_d = bus_powered_controller_current_q;        // [RQ12] [RQ9]
        end
    end

    // Flag a stored pattern the loader should not have written; no repair,
    // the ports still follow the register exactly as written
    assign disable_pattern_err_d = !hpcr_is_legal_mask(reg_mask);         // [RQ4]

    // Register stage for control outputs
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            port_disabled_q       <= '0;
            rpt_max_power_q       <= HPCR_RST_SP_MAX_PWR;
            rpt_ctrl_current_q    <= HPCR_RST_SP_CTRL_CUR;
            disable_pattern_err_q <= 1'b0;
        end else begin
            port_disabled_q       <= port_disabled_d;
            rpt_max_power_q       <= rpt_max_power_d;
            rpt_ctrl_current_q    <= rpt_ctrl_current_d;
            disable_pattern_err_q <= disable_pattern_err_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port gate; fed from the next and the registered mask together so a host request cannot slip
    // through during the cycle the mask changes
    assign pif.disable_mask = port_disabled_d | port_disabled_q;          // [RQ3]
    assign pif.enable_req   = host_port_enable_req;
    assign pif.disable_req  = host_port_disable_req;
    assign port_enabled     = pif.port_enabled;

    hpcr_port_gate u_gate (
        .sys_clk (sys_clk),
        .srst    (srst),
        .pif     (pif.gate)
    );

endmodule : hpcr_regs

/* tb/hpcr_loader_model.sv */
// Configuration loader model that writes one legal image into the bank
`timescale 1ns/100ps
module hpcr_loader_model
    import hpcr_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       go,
    input  wire logic [2:0] n_dis,
    input  wire logic [7:0] sp_pwr,
    input  wire logic [7:0] bp_pwr,
    output logic            ld_wr,
    output logic      [7:0] ld_addr,
    output logic      [7:0] ld_wdata
);
    logic [2:0] step_q;
    logic [2:0] step_d;
    logic [7:0] mask;
    logic [7:0] sp_c;

    ////////////////////////////////////////////////////////////////////////////
    // Run of disabled ports only grows down from port 4
    assign mask = 8'h1e & ~(8'h1e >> n_dis);
    // Self-powered figures held at 100 mA, i.e. 50 units
    assign sp_c = (sp_pwr > 8'h32) ? 8'h32 : sp_pwr;
    assign ld_wr = step_q != 3'h0;
    assign ld_addr = 8'h0a + {5'h00, step_q};

    ////////////////////////////////////////////////////////////////////////////
    // Five back-to-back writes, 0x0b up to 0x0f
    always_comb begin
        step_d = (step_q == 3'h0) ? {2'h0, go} : step_q + 3'h1;
        if (step_q == 3'h5) step_d = 3'h0;
        case (step_q)
            3'h1: ld_wdata = mask;
            3'h2: ld_wdata = sp_c;
            3'h3: ld_wdata = bp_pwr;
            3'h4: ld_wdata = sp_c >> 1;
            default: ld_wdata = bp_pwr >> 1;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        step_q <= srst ? 3'h0 : step_d;
    end
endmodule : hpcr_loader_model

/* tb/hpcr_regs_checker.sv */
// Concurrent checks on the ports of the configuration bank
`timescale 1ns/100ps
module hpcr_regs_checker
    import hpcr_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       srst,
    input wire logic       cfg_wr,
    input wire logic       cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata_q,
    input wire logic       cfg_rvalid_q,
    input wire logic       self_powered,
    input wire logic       default_config_sel,
    input wire logic [1:0] port_disable_straps,
    input wire logic [3:0] port_enabled,
    input wire logic [3:0] port_disabled_q,
    input wire logic [7:0] rpt_max_power_q,
    input wire logic [7:0] rpt_ctrl_current_q,
    input wire logic       disable_pattern_err_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    function automatic logic [3:0] strap_dec(logic [1:0] s);
        return (s == 2'h0) ? HPCR_DIS_NONE : (s == 2'h1) ? HPCR_DIS_P4 :
               (s == 2'h2) ? HPCR_DIS_P43 : HPCR_DIS_P432;
    endfunction : strap_dec

    ////////////////////////////////////////////////////////////////////////////
    // A write followed by a quiet cycle, so the next edge shows its effect
    sequence wr_s(logic [7:0] a);
        cfg_wr && cfg_addr == a ##1 !cfg_wr && !srst;
    endsequence

    reset_zero_a: assert property (disable iff (1'b0) srst |=>
        port_disabled_q == 4'h0 && port_enabled == 4'h0 && !cfg_rvalid_q &&
        rpt_max_power_q == 8'h00 && rpt_ctrl_current_q == 8'h00)
        else $error("outputs not cleared by reset");
    rdata_idle_a: assert property (!cfg_rvalid_q |-> cfg_rdata_q == HPCR_RDATA_IDLE)
        else $error("read data not idle");
    reserved_zero_a: assert property (cfg_rd && cfg_addr == HPCR_OFS_BP_PORT_DIS
        |=> cfg_rvalid_q && (cfg_rdata_q & ~HPCR_PORT_DIS_MASK) == 8'h00)
        else $error("reserved bits read nonzero");
    no_enable_a: assert property ((port_disabled_q & port_enabled) == 4'h0)
        else $error("disabled port enabled");
    strap_mask_a: assert property (default_config_sel
        |=> port_disabled_q == strap_dec($past(port_disable_straps)))
        else $error("strap decode wrong");
    mask_follow_a: assert property (wr_s(HPCR_OFS_BP_PORT_DIS) ##0
        (!self_powered && !default_config_sel) |=> port_disabled_q == $past(cfg_wdata[4:1], 2))
        else $error("bus-powered mask not applied");
    pattern_flag_a: assert property (wr_s(HPCR_OFS_BP_PORT_DIS) |=>
        disable_pattern_err_q == !($past(cfg_wdata[4:1], 2) inside {4'h0, 4'h8, 4'hc, 4'he, 4'hf}))
        else $error("pattern flag wrong");
    rpt_sp_a: assert property (wr_s(HPCR_OFS_SP_MAX_PWR) ##0 self_powered
        |=> rpt_max_power_q == $past(cfg_wdata, 2)) else $error("self-powered power not reported");
    rpt_bp_a: assert property (wr_s(HPCR_OFS_BP_MAX_PWR) ##0 !self_powered
        |=> rpt_max_power_q == $past(cfg_wdata, 2)) else $error("bus-powered power not reported");
    rpt_bp_cur_a: assert property (wr_s(HPCR_OFS_BP_CTRL_CUR) ##0 !self_powered
        |=> rpt_ctrl_current_q == $past(cfg_wdata, 2)) else $error("current not reported");
    rpt_sp_cur_a: assert property (wr_s(HPCR_OFS_SP_CTRL_CUR) ##0 self_powered
        |=> rpt_ctrl_current_q == $past(cfg_wdata, 2))
        else $error("self-powered current not reported");
endmodule : hpcr_regs_checker

bind hpcr_regs hpcr_regs_checker hpcr_regs_checker_inst (.*);

/* tb/testbench.sv */
// Self-checking bench for the hub power configuration bank
`timescale 1ns/100ps
module testbench
    import hpcr_pkg::*;
;
    logic              sys_clk, srst, tb_wr, cfg_rd, go;
    logic              self_powered, default_config_sel;
    logic       [1:0]  port_disable_straps;
    logic       [2:0]  n_dis;
    logic       [3:0]  host_port_enable_req, host_port_disable_req;
    logic       [7:0]  tb_addr, tb_wdata, sp_pwr, bp_pwr;
    wire logic         cfg_wr, ld_wr;
    wire logic  [7:0]  cfg_addr, cfg_wdata, ld_addr, ld_wdata;
    logic       [7:0]  cfg_rdata_q, rpt_max_power_q, rpt_ctrl_current_q;
    logic       [3:0]  port_enabled, port_disabled_q;
    logic              cfg_rvalid_q, disable_pattern_err_q;
    logic       [7:0]  exp_q[$];
    int                num_errors = 0;
    int                compares = 0;

    // Loader owns the write lines while its image goes in
    assign cfg_wr = ld_wr | tb_wr;
    assign cfg_addr = ld_wr ? ld_addr : tb_addr;
    assign cfg_wdata = ld_wr ? ld_wdata : tb_wdata;

    hpcr_regs hpcr_regs_inst (.*);
    hpcr_loader_model hpcr_loader_model_inst (.*);

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        tb_wr    <= 1'b1;
        tb_addr  <= a;
        tb_wdata <= d;
        @(posedge sys_clk);
        tb_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        cfg_rd  <= 1'b1;
        tb_addr <= a;
        exp_q.push_back(e);
        @(posedge sys_clk);
        cfg_rd <= 1'b0;
    endtask : rd

    // Levels show two edges after the cause; sample between edges
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : settle

    task automatic all_zero();
        for (int i = 0; i < 5; i++) rd(8'h0b + i[7:0], 8'h00);
    endtask : all_zero

    task automatic close_out();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    // Each read answer is matched to the oldest expectation
    always @(negedge sys_clk) begin
        if (cfg_rvalid_q === 1'b1) chk(cfg_rdata_q, exp_q.pop_front());
    end

    initial begin
        #(8 * 5000);
        num_errors++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] d;
        logic [7:0] c;
        logic [3:0] m;
        {srst, tb_wr, cfg_rd, go, self_powered, default_config_sel} = 6'h20;
        {port_disable_straps, n_dis, host_port_enable_req, host_port_disable_req} = 13'h0;
        {tb_addr, tb_wdata, sp_pwr, bp_pwr} = 32'h0;
        d = 8'($urandom(28413));
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        all_zero();
        wr(8'h0b, 8'hff);
        rd(8'h0b, 8'h1e);
        // Even offsets written while self-powered so both report sets are exercised
        for (int i = 0; i < 5; i++) begin
            d = 8'($urandom);
            @(posedge sys_clk);
            self_powered <= i[0];
            wr(8'h0b + i[7:0], d);
            rd(8'h0b + i[7:0], (i == 0) ? d & HPCR_PORT_DIS_MASK : d);
        end
        @(posedge sys_clk);
        self_powered <= 1'b0;
        wr(8'h10, 8'h5a);
        rd(8'h10, 8'h00);
        rd(8'h0a, 8'h00);
        // Each legal disable run, reports in both powering modes
        for (int n = 0; n < 5; n++) begin
            @(posedge sys_clk);
            n_dis  <= n[2:0];
            sp_pwr <= 8'($urandom);
            bp_pwr <= 8'($urandom);
            go     <= 1'b1;
            @(posedge sys_clk);
            go <= 1'b0;
            repeat (7) @(posedge sys_clk);
            host_port_enable_req <= 4'hf;
            @(posedge sys_clk);
            host_port_enable_req <= 4'h0;
            settle();
            m = 4'hf << (4 - n);
            c = (sp_pwr > 8'h32) ? 8'h32 : sp_pwr;
            chk({4'h0, port_disabled_q}, {4'h0, m});
            chk({4'h0, port_enabled}, {4'h0, ~m});
            chk({7'h00, disable_pattern_err_q}, 8'h00);
            chk(rpt_max_power_q, bp_pwr);
            chk(rpt_ctrl_current_q, bp_pwr >> 1);
            @(posedge sys_clk);
            self_powered <= 1'b1;
            settle();
            chk(rpt_max_power_q, c);
            chk(rpt_ctrl_current_q, c >> 1);
            @(posedge sys_clk);
            self_powered <= 1'b0;
        end
        // Straps take over under the internal default
        default_config_sel <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            @(posedge sys_clk);
            port_disable_straps <= s[1:0];
            settle();
            m = 4'hf << (4 - s);
            chk({4'h0, port_disabled_q}, {4'h0, m});
        end
        @(posedge sys_clk);
        default_config_sel <= 1'b0;
        wr(8'h0b, 8'h04);
        settle();
        chk({7'h00, disable_pattern_err_q}, 8'h01);
        chk({4'h0, port_disabled_q}, 8'h02);
        // Host asks for every port; only port 2 must stay down
        @(posedge sys_clk);
        host_port_enable_req <= 4'hf;
        @(posedge sys_clk);
        host_port_enable_req <= 4'h0;
        settle();
        chk({4'h0, port_enabled}, 8'h0d);
        @(posedge sys_clk);
        host_port_disable_req <= 4'hf;
        @(posedge sys_clk);
        host_port_disable_req <= 4'h0;
        settle();
        chk({4'h0, port_enabled}, 8'h00);
        // Reset in mid-run clears the bank again
        @(posedge sys_clk);
        srst <= 1'b1;
        @(posedge sys_clk);
        srst <= 1'b0;
        all_zero();
        settle();
        chk(8'(exp_q.size()), 8'h00);
        close_out();
    end
endmodule : testbench
